/* File: sdpo_parallel_out.sv */
// Function
// - hold is input; data, flags, strobe outputs
// - narrow width: only low lines carry data
// - strobe high while new word presented
// - overrange when input outside zero-to-span
// - overrange when value beyond code display range
// - signed BCD range limited to -9999..9999
// - zero offset is 0 %, span +100 %
// - contact closure in monitor, function 0: tare
// - tare stores offset; output shows 0 % value
// - binary codes: line n weighs 2**n
// - mode 1 is monitor: measure and output
// - load ratio scales partial-load span calibration
// - strobe length 1..50 ms, default 1
// - code 0..4: BCD, sbin, offset, twos, gray
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
module sdpo_parallel_out #(
  parameter int CYC_PER_MS = sdpo_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  // wishbone slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  // measurement from the front end
  input  wire logic                              meas_valid,
  input  wire logic signed [sdpo_pkg::MEAS_W-1:0] meas_value,
  // connector pins
  input  wire logic                              hold_req,
  input  wire logic                              contact_input,
  output sdpo_pkg::sdpo_word_s                   pword,
  output logic                                   data_valid_strobe,
  // interrupt
  output logic                                   irq
);
  import sdpo_pkg::*;

  // ==========================================================================
  // bcd conversion
  function automatic logic [15:0] to_bcd(input logic [13:0] b);
    logic [29:0] s;
    s = {16'h0000, b};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (s[14+4*d +: 4] > 4'h4) begin
          s[14+4*d +: 4] = s[14+4*d +: 4] + 4'h3;
        end
      end
      s = {s[28:0], 1'b0};
    end
    return s[29:14];
  endfunction : to_bcd

  // ==========================================================================
  // registers
  sdpo_ctrl_s                  ctrl_r;
  logic [STRB_W-1:0]           strb_ms_r;
  logic signed [MEAS_W-1:0]    zero_r;
  logic [MEAS_W-1:0]           span_r;
  logic [RATIO_W-1:0]          ratio_r;
  logic signed [TARE_W-1:0]    tare_r;
  logic signed [DISP_W-1:0]    disp0_r;
  logic signed [DISP_W-1:0]    disp1_r;
  logic [IRQ_W-1:0]            stat_r;
  logic [IRQ_W-1:0]            mask_r;
  logic signed [MEAS_W-1:0]    last_x_r;
  logic                        contact_d_r;
  sdpo_state_e                 st_r;
  logic [34:0]                 rem_r;
  logic [53:0]                 quo_r;
  logic [33:0]                 den_r;
  logic [5:0]                  dcnt_r;
  logic                        neg_r;
  logic                        in_ovr_r;
  logic signed [VAL_W-1:0]     val_r;
  logic [STRB_CNT_W-1:0]       strb_cnt_r;

  // ==========================================================================
  // bus decode
  logic [31:0] bmask;
  logic [31:0] rd_mux;
  logic [31:0] wdat;
  logic        bus_req;
  logic        wr_en;
  assign bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_en   = bus_req & wb_we_i & wb_ack_o;   // write lands on the ack edge
  assign wdat    = (rd_mux & ~bmask) | (wb_dat_i & bmask);

  logic wr_ctrl, wr_strb, wr_zero, wr_span, wr_ratio, wr_tare;
  logic wr_disp0, wr_disp1, wr_stat, wr_mask;
  assign wr_ctrl  = wr_en && wb_adr_i == OFS_CTRL;
  assign wr_strb  = wr_en && wb_adr_i == OFS_STRB;
  assign wr_zero  = wr_en && wb_adr_i == OFS_ZERO;
  assign wr_span  = wr_en && wb_adr_i == OFS_SPAN;
  assign wr_ratio = wr_en && wb_adr_i == OFS_RATIO;
  assign wr_tare  = wr_en && wb_adr_i == OFS_TARE;
  assign wr_disp0 = wr_en && wb_adr_i == OFS_DISP0;
  assign wr_disp1 = wr_en && wb_adr_i == OFS_DISP1;
  assign wr_stat  = wr_en && wb_adr_i == OFS_STAT;
  assign wr_mask  = wr_en && wb_adr_i == OFS_MASK;

  // read mux, unmapped offsets read zero
  always_comb begin
    case (wb_adr_i)
      OFS_CTRL:   rd_mux = 32'(ctrl_r);
      OFS_STRB:   rd_mux = 32'(strb_ms_r);
      OFS_ZERO:   rd_mux = 32'(zero_r);
      OFS_SPAN:   rd_mux = 32'(span_r);
      OFS_RATIO:  rd_mux = 32'(ratio_r);
      OFS_TARE:   rd_mux = 32'(tare_r);
      OFS_DISP0:  rd_mux = 32'(disp0_r);
      OFS_DISP1:  rd_mux = 32'(disp1_r);
      OFS_STAT:   rd_mux = 32'(stat_r);
      OFS_MASK:   rd_mux = 32'(mask_r);
      OFS_RESULT: rd_mux = 32'(pword);
      OFS_VALUE:  rd_mux = 32'(val_r);
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // setting registers; out-of-range strobe and ratio values are clamped
  logic [STRB_W-1:0]  strb_wv;
  logic [RATIO_W-1:0] ratio_wv;
  assign strb_wv  = wdat[STRB_W-1:0] < STRB_MIN ? STRB_MIN :
                    wdat[STRB_W-1:0] > STRB_MAX ? STRB_MAX : wdat[STRB_W-1:0];
  assign ratio_wv = wdat[RATIO_W-1:0] < RATIO_MIN ? RATIO_MIN :
                    wdat[RATIO_W-1:0] > RATIO_FULL ? RATIO_FULL : wdat[RATIO_W-1:0];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= '{hold_pol: 1'b0, di_func: DI_TARE, width_sel: 3'h0,
                     code: CODE_BCD, mode: MODE_MONITOR};
      strb_ms_r <= STRB_RST;
      zero_r    <= '0;
      span_r    <= SPAN_RST;
      ratio_r   <= RATIO_FULL;
      disp0_r   <= DISP0_RST;
      disp1_r   <= DISP1_RST;
      mask_r    <= '0;
    end else begin
      if (wr_ctrl)  ctrl_r    <= sdpo_ctrl_s'(wdat[CTRL_W-1:0]);
      if (wr_strb)  strb_ms_r <= strb_wv;
      if (wr_zero)  zero_r    <= wdat[MEAS_W-1:0];
      if (wr_span)  span_r    <= wdat[MEAS_W-1:0];
      if (wr_ratio) ratio_r   <= ratio_wv;
      if (wr_disp0) disp0_r   <= wdat[DISP_W-1:0];
      if (wr_disp1) disp1_r   <= wdat[DISP_W-1:0];
      if (wr_mask)  mask_r    <= wdat[IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // tare from the contact input
  logic                     monitor;
  logic                     tare_evt;
  logic signed [TARE_W-1:0] cur_ofs;
  assign monitor  = ctrl_r.mode == MODE_MONITOR;
  assign tare_evt = contact_input & ~contact_d_r & monitor
                    & (ctrl_r.di_func == DI_TARE);
  assign cur_ofs  = TARE_W'(last_x_r) - TARE_W'(zero_r);

  // hardware tare wins over a software write in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      contact_d_r <= 1'b0;
      last_x_r    <= '0;
      tare_r      <= '0;
    end else begin
      contact_d_r <= contact_input;
      if (meas_valid) last_x_r <= meas_value;
      if (tare_evt) begin
        tare_r <= cur_ofs;
      end else if (wr_tare) begin
        tare_r <= wdat[TARE_W-1:0];
      end
    end
  end

  // ==========================================================================
  // scaling: out = disp0 + (x-zero-tare) * ratio * (disp1-disp0) / (span*1000)
  logic signed [TARE_W-1:0]   g;
  logic signed [TARE_W:0]     f;
  logic [TARE_W:0]            f_mag;
  logic signed [DISP_W:0]     rng;
  logic [DISP_W:0]            r_mag;
  logic [53:0]                num_mag;
  logic [33:0]                den;
  logic [34:0]                g_prod;
  logic [34:0]                g_lim;
  logic                       in_out;
  assign g       = TARE_W'(meas_value) - TARE_W'(zero_r);
  assign f       = (TARE_W+1)'(g) - (TARE_W+1)'(tare_r);
  assign f_mag   = f < 0 ? (TARE_W+1)'(-f) : f;
  assign rng     = (DISP_W+1)'(disp1_r) - (DISP_W+1)'(disp0_r);
  assign r_mag   = rng < 0 ? (DISP_W+1)'(-rng) : rng;
  assign num_mag = 54'(f_mag) * 54'(ratio_r) * 54'(r_mag);
  assign den     = 34'(span_r) * 34'(RATIO_FULL);
  // partial-load calibration widens full scale to span*1000/ratio
  assign g_prod  = 35'(g[MEAS_W-1:0]) * 35'(ratio_r);
  assign g_lim   = 35'(span_r) * 35'(RATIO_FULL);
  assign in_out  = g[TARE_W-1] | (g_prod > g_lim);

  // restoring divider step, one quotient bit per clock
  logic [34:0] div_trial;
  logic        div_ge;
  assign div_trial = {rem_r[33:0], quo_r[53]};
  assign div_ge    = div_trial >= {1'b0, den_r};

  logic [53:0]             q_fin;
  logic [19:0]             q_sat;
  logic signed [VAL_W-1:0] val_nxt;
  // last step's bit folded in here, since val_r is taken on that same edge
  assign q_fin   = {quo_r[52:0], div_ge};
  assign q_sat   = |q_fin[53:20] ? 20'hF_FFFF : q_fin[19:0];  // huge quotient still overranges
  assign val_nxt = VAL_W'(disp0_r) + (neg_r ? -VAL_W'(q_sat) : VAL_W'(q_sat));

  // ==========================================================================
  // output formatting and range check per code
  logic [VAL_W-1:0] v_mag;
  logic [15:0]      raw;
  logic [15:0]      wmask;
  logic             rng_out;
  sdpo_word_s       word_nxt;
  assign v_mag = val_r < 0 ? VAL_W'(-val_r) : val_r;

  always_comb begin
    case (ctrl_r.code)
      CODE_BCD: begin
        raw     = to_bcd(v_mag[13:0]);
        rng_out = val_r < -BCD_MAX || val_r > BCD_MAX;
      end
      CODE_SBIN: begin
        raw     = v_mag[15:0];
        rng_out = val_r < -SBIN_MAX || val_r > SBIN_MAX;
      end
      CODE_OFFS: begin
        raw     = val_r[15:0];
        rng_out = val_r < 0 || val_r > UBIN_MAX;
      end
      CODE_TWOS: begin
        raw     = val_r[15:0];
        rng_out = val_r < TWOS_MIN || val_r > SBIN_MAX;
      end
      CODE_GRAY: begin
        raw     = val_r[15:0] ^ {1'b0, val_r[15:1]};
        rng_out = val_r < 0 || val_r > UBIN_MAX;
      end
      default: begin
        raw     = val_r[15:0];
        rng_out = 1'b1;
      end
    endcase
  end

  // unused high lines are driven low
  always_comb begin
    case (ctrl_r.width_sel)
      3'h0:    wmask = 16'hFFFF;
      3'h1:    wmask = 16'h3FFF;
      3'h2:    wmask = 16'h0FFF;
      3'h3:    wmask = 16'h03FF;
      default: wmask = 16'h00FF;
    endcase
  end

  assign word_nxt.data = raw & wmask;
  assign word_nxt.sign = val_r < 0;
  assign word_nxt.ovr  = in_ovr_r | rng_out;

  // ==========================================================================
  // sequencer: take sample, divide, present unless held
  logic hold_act;
  logic start;
  logic load;
  assign hold_act = ctrl_r.hold_pol ? hold_req : ~hold_req;
  assign start    = st_r == ST_IDLE && meas_valid && monitor;
  assign load     = st_r == ST_FMT && !hold_act;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: if (start) st_r <= ST_DIV;
        ST_DIV:  if (dcnt_r == 6'h01) st_r <= ST_FMT;
        ST_FMT:  st_r <= ST_IDLE;  // a held word is dropped, next sample retries
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rem_r    <= '0;
      quo_r    <= '0;
      den_r    <= '0;
      dcnt_r   <= '0;
      neg_r    <= 1'b0;
      in_ovr_r <= 1'b0;
      val_r    <= '0;
    end else if (start) begin
      rem_r    <= '0;
      quo_r    <= num_mag;
      den_r    <= den;
      dcnt_r   <= DIV_STEPS;
      neg_r    <= f[TARE_W] ^ rng[DISP_W];
      in_ovr_r <= in_out;
    end else if (st_r == ST_DIV) begin
      rem_r  <= div_ge ? div_trial - {1'b0, den_r} : div_trial;
      quo_r  <= {quo_r[52:0], div_ge};
      dcnt_r <= dcnt_r - 6'h01;
      if (dcnt_r == 6'h01) val_r <= val_nxt;
    end
  end

  // ==========================================================================
  // connector outputs and strobe timer
  logic [STRB_CNT_W-1:0] strb_len;
  assign strb_len = STRB_CNT_W'(32'(strb_ms_r) * CYC_PER_MS);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pword             <= '0;
      data_valid_strobe <= 1'b0;
      strb_cnt_r        <= '0;
    end else if (load) begin
      pword             <= word_nxt;
      data_valid_strobe <= 1'b1;
      strb_cnt_r        <= strb_len - STRB_CNT_W'(1);
    end else if (strb_cnt_r != '0) begin
      strb_cnt_r <= strb_cnt_r - STRB_CNT_W'(1);
    end else begin
      data_valid_strobe <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupts: sticky, write one to clear, a new event beats the clear
  logic [IRQ_W-1:0] ev;
  assign ev[IRQ_DONE] = load;
  assign ev[IRQ_OVR]  = load & word_nxt.ovr;
  assign ev[IRQ_TARE] = tare_evt;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= '0;
      irq    <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~(wr_stat ? wdat[IRQ_W-1:0] : '0)) | ev;
      irq    <= |(stat_r & mask_r);
    end
  end

  // ==========================================================================
  // checks
  sequence s_word_ready;
    st_r == ST_FMT && !hold_act;
  endsequence

  a_strobe_on_load: assert property (@(posedge clock) disable iff (!rst_b)
    s_word_ready |=> data_valid_strobe && strb_cnt_r == $past(strb_len) - 1)
    else $error("strobe not raised with new word");

  a_strobe_length: assert property (@(posedge clock) disable iff (!rst_b)
    strb_cnt_r <= STRB_CNT_W'(32'(STRB_MAX) * CYC_PER_MS))
    else $error("strobe counter beyond maximum length");

  a_hold_freeze: assert property (@(posedge clock) disable iff (!rst_b)
    hold_act |=> $stable(pword))
    else $error("output changed during hold");

  a_width_lines: assert property (@(posedge clock) disable iff (!rst_b)
    s_word_ready ##0 ctrl_r.width_sel == 3'h4 |=> pword.data[15:8] == 8'h00)
    else $error("high data lines driven in 8-bit width");

  a_bcd_range: assert property (@(posedge clock) disable iff (!rst_b)
    s_word_ready ##0 ctrl_r.code == CODE_BCD ##0 val_r > BCD_MAX |=> pword.ovr)
    else $error("bcd value beyond 9999 without overrange");

  a_input_span: assert property (@(posedge clock) disable iff (!rst_b)
    s_word_ready ##0 in_ovr_r |=> pword.ovr)
    else $error("input outside span without overrange");

  a_twos_bits: assert property (@(posedge clock) disable iff (!rst_b)
    s_word_ready ##0 ctrl_r.code == CODE_TWOS ##0 ctrl_r.width_sel == 3'h0
    |=> pword.data == $past(val_r[15:0]))
    else $error("two's complement word mismatch");

  a_tare_store: assert property (@(posedge clock) disable iff (!rst_b)
    tare_evt |=> tare_r == $past(cur_ofs))
    else $error("tare offset not stored");

  a_mode_gate: assert property (@(posedge clock) disable iff (!rst_b)
    st_r == ST_IDLE && !monitor |=> st_r == ST_IDLE)
    else $error("conversion started outside monitor mode");

  // divide cycles counted here, so no long repetition has to be unrolled
  logic [5:0] div_len_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_len_r <= 6'h00;
    end else begin
      div_len_r <= (st_r == ST_DIV) ? div_len_r + 6'h01 : 6'h00;
    end
  end

  sequence s_div_done;
    st_r == ST_FMT && div_len_r == DIV_STEPS;
  endsequence

  a_cycle_time: assert property (@(posedge clock) disable iff (!rst_b)
    start |=> ##54 s_div_done)
    else $error("conversion took wrong number of cycles");

endmodule : sdpo_parallel_out

/* File: sdpo_pkg.sv */
package sdpo_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STRB   = 8'h04;
  localparam logic [7:0] OFS_ZERO   = 8'h08;
  localparam logic [7:0] OFS_SPAN   = 8'h0C;
  localparam logic [7:0] OFS_RATIO  = 8'h10;
  localparam logic [7:0] OFS_TARE   = 8'h14;
  localparam logic [7:0] OFS_DISP0  = 8'h18;
  localparam logic [7:0] OFS_DISP1  = 8'h1C;
  localparam logic [7:0] OFS_STAT   = 8'h20;
  localparam logic [7:0] OFS_MASK   = 8'h24;
  localparam logic [7:0] OFS_RESULT = 8'h28;
  localparam logic [7:0] OFS_VALUE  = 8'h2C;

  // ==========================================================================
  // field layouts and widths
  localparam int CTRL_W  = 11;  // control word, laid out as sdpo_ctrl_s
  localparam int STRB_W  = 6;
  localparam int MEAS_W  = 24;
  localparam int RATIO_W = 10;
  localparam int TARE_W  = 25;
  localparam int DISP_W  = 17;
  localparam int VAL_W   = 22;
  localparam int IRQ_W   = 3;
  localparam int IRQ_DONE = 0;  // new word presented
  localparam int IRQ_OVR  = 1;  // word presented with overrange
  localparam int IRQ_TARE = 2;  // tare taken from contact input

  // ==========================================================================
  // modes, input functions and codes
  localparam logic [1:0] MODE_MONITOR = 2'h1;
  localparam logic [1:0] DI_TARE      = 2'h0;
  localparam logic [2:0] CODE_BCD     = 3'h0;
  localparam logic [2:0] CODE_SBIN    = 3'h1;
  localparam logic [2:0] CODE_OFFS    = 3'h2;
  localparam logic [2:0] CODE_TWOS    = 3'h3;
  localparam logic [2:0] CODE_GRAY    = 3'h4;

  // ==========================================================================
  // limits and reset values
  localparam logic [RATIO_W-1:0] RATIO_FULL = 10'h3E8;      // 100.0 % in tenths
  localparam logic [RATIO_W-1:0] RATIO_MIN  = 10'h064;      // 10.0 %
  localparam logic [STRB_W-1:0]  STRB_MIN   = 6'h01;
  localparam logic [STRB_W-1:0]  STRB_MAX   = 6'h32;        // 50 ms
  localparam logic [STRB_W-1:0]  STRB_RST   = 6'h01;        // 1 ms
  localparam logic [DISP_W-1:0]  DISP0_RST  = 17'h1_FC18;   // -1000
  localparam logic [DISP_W-1:0]  DISP1_RST  = 17'h0_03E8;   // 1000
  localparam logic [MEAS_W-1:0]  SPAN_RST   = 24'h10_0000;
  localparam int BCD_MAX  = 9999;
  localparam int SBIN_MAX = 32767;
  localparam int TWOS_MIN = -32768;
  localparam int UBIN_MAX = 65535;

  // ==========================================================================
  // timing
  localparam int CLK_NS     = 40;
  localparam int MS_NS      = 1000000;
  localparam int MS_CYCLES  = MS_NS / CLK_NS;
  localparam int STRB_CNT_W = 21;
  localparam logic [5:0] DIV_STEPS = 6'h36;  // one quotient bit per step

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       hold_pol;  // 0: hold when pin low, 1: hold when pin high
    logic [1:0] di_func;
    logic [2:0] width_sel; // 0..4 = 16, 14, 12, 10, 8 bits
    logic [2:0] code;
    logic [1:0] mode;
  } sdpo_ctrl_s;

  typedef struct packed {
    logic [15:0] data;
    logic        sign;
    logic        ovr;
  } sdpo_word_s;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FMT} sdpo_state_e;

endpackage : sdpo_pkg

/* File: sdpo_ctrl_model.sv */
module sdpo_ctrl_model (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // connector pins
  input  wire sdpo_pkg::sdpo_word_s pword,
  input  wire logic                 data_valid_strobe,
  output logic                      hold_req,
  // bench side
  input  wire logic                 hold_on,
  output sdpo_pkg::sdpo_word_s      last_word,
  output logic [7:0]                words,
  output logic [7:0]                pulse_len
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdpo_pkg::*;
  logic       strb_r;
  logic [7:0] cnt_r;
  // pin held low to request hold, matching the reset polarity
  assign hold_req = ~hold_on;
  // words taken only while the strobe stands; length kept at its fall
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strb_r    <= 1'b0;
      cnt_r     <= 8'h00;
      last_word <= '0;
      words     <= 8'h00;
      pulse_len <= 8'h00;
    end else begin
      strb_r <= data_valid_strobe;
      if (data_valid_strobe) begin
        cnt_r     <= strb_r ? cnt_r + 8'h01 : 8'h01;
        last_word <= pword;
      end
      if (data_valid_strobe && !strb_r)
        words <= words + 8'h01;
      if (!data_valid_strobe && strb_r)
        pulse_len <= cnt_r;
    end
  end
endmodule : sdpo_ctrl_model

/* File: sdpo_parallel_out_tb.sv */
module sdpo_parallel_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdpo_pkg::*;
  // ==========
  // signals
  localparam int CPM = 4;  // short millisecond keeps strobes brief
  localparam logic [17:0] ALL = 18'h3_FFFF;
  localparam logic [23:0] X100 = 24'h10_0000;
  localparam logic [23:0] X50 = 24'h08_0000;
  localparam logic [23:0] X25 = 24'h04_0000;
  logic        clock = 0, rst_b = 0, cyc = 0, stb = 0, we = 0;
  logic        meas_valid = 0, hold_on = 0, contact_input = 0;
  logic [7:0]  adr = 0, words, pulse_len;
  logic [31:0] dat = 0, rd, dat_o;
  logic [23:0] meas_value = 0;
  logic        ack, hold_req, strobe, irq;
  sdpo_word_s  pword, last_word;
  int          failures = 0, checks_done = 0;
  sdpo_parallel_out #(.CYC_PER_MS(CPM)) uut (.clock(clock), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .meas_valid(meas_valid),
    .meas_value(meas_value), .hold_req(hold_req), .contact_input(contact_input),
    .pword(pword), .data_valid_strobe(strobe), .irq(irq));
  sdpo_ctrl_model far (.clock(clock), .rst_b(rst_b), .pword(pword),
    .data_valid_strobe(strobe), .hold_req(hold_req), .hold_on(hold_on),
    .last_word(last_word), .words(words), .pulse_len(pulse_len));
  // ==========
  // clock and watchdog, generous against about 1300 cycles of tests
  initial begin
    forever #20 clock = ~clock;
  end
  initial begin
    #1000000;
    failures++;
    end_of_test();
  end
  // ==========
  // shared tasks
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk
  // one classic cycle, then one idle cycle before the next
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge clock);
  endtask : wb
  // len 0 means no word may appear
  task meas(input logic [23:0] x, input logic [17:0] m, input logic [17:0] e, input int len);
    int n;
    logic [7:0] w0;
    logic [17:0] p0;
    w0 = words;
    p0 = pword;
    meas_valid <= 1;
    meas_value <= x;
    @(posedge clock);
    meas_valid <= 0;
    n = 0;
    if (len == 0) begin
      repeat (70) @(posedge clock);
      chk("no word", {w0, 6'h00, p0}, {words, 6'h00, pword});
    end else begin
      while (words == w0 && n < 100) begin
        @(posedge clock);
        n++;
      end
      while (strobe !== 1'b0 && n < 300) begin
        @(posedge clock);
        n++;
      end
      @(posedge clock);
      chk("word", e & m, last_word & m);
      chk("strobe len", len, pulse_len);
      chk("new word", 32'h1, 32'(words != w0));
    end
  endtask : meas
  // ==========
  // scenarios
  task t_reset;
    chk("pword", 0, pword);
    chk("irq", 0, irq);
    wb(0, OFS_CTRL, 0);
    chk("ctrl", 1, rd);
    wb(0, OFS_STRB, 0);
    chk("strb", STRB_RST, rd);
    wb(0, 8'h30, 0);
    chk("unmapped", 0, rd);
    $display("reset test done");
  endtask : t_reset
  task t_codes;
    meas(X100, ALL, {16'h1000, 2'b00}, CPM);
    meas(X25, ALL, {16'h0500, 2'b10}, CPM);
    wb(1, OFS_CTRL, 32'h5);
    meas(X25, ALL, {16'h01F4, 2'b10}, CPM);
    wb(1, OFS_CTRL, 32'hD);
    meas(X25, ALL, {16'hFE0C, 2'b10}, CPM);
    wb(1, OFS_CTRL, 32'h11);
    meas(X100, ALL, {16'h021C, 2'b00}, CPM);
    wb(1, OFS_CTRL, 32'h9);
    meas(X25, 18'h2, 18'h2, CPM);
    $display("code test done");
  endtask : t_codes
  task t_ovr;
    wb(1, OFS_CTRL, 32'h1);
    meas(24'hFF_FFFF, 18'h1, 18'h1, CPM);
    meas(24'h10_0001, 18'h1, 18'h1, CPM);
    meas(X100, 18'h1, 18'h0, CPM);
    wb(1, OFS_RATIO, 32'h64);
    meas(X100, ALL, {16'h0800, 2'b10}, CPM);
    wb(1, OFS_RATIO, 32'h3E8);
    wb(1, OFS_DISP1, 32'h2EE0);
    meas(X100, 18'h1, 18'h1, CPM);
    wb(1, OFS_CTRL, 32'h85);
    wb(1, OFS_DISP1, 32'h7FFF);
    meas(X100, {16'h00FF, 2'b11}, {16'h00FF, 2'b00}, CPM);
    wb(1, OFS_DISP1, 32'h3E8);
    wb(1, OFS_CTRL, 32'h1);
    $display("overrange test done");
  endtask : t_ovr
  task t_hold;
    hold_on <= 1;
    meas(X100, 0, 0, 0);
    hold_on <= 0;
    meas(X100, ALL, {16'h1000, 2'b00}, CPM);
    wb(1, OFS_CTRL, 32'h2);
    meas(X100, 0, 0, 0);
    wb(1, OFS_CTRL, 32'h401);
    meas(X100, 0, 0, 0);
    wb(1, OFS_CTRL, 32'h1);
    $display("hold test done");
  endtask : t_hold
  task t_irq;
    wb(1, OFS_STRB, 32'h3F);
    wb(0, OFS_STRB, 0);
    chk("strb clamp", 32'h32, rd);
    wb(1, OFS_STRB, 32'h3);
    wb(1, OFS_STAT, 32'h7);
    meas(X100, ALL, {16'h1000, 2'b00}, 3 * CPM);
    chk("irq masked", 0, irq);
    wb(0, OFS_STAT, 0);
    chk("stat", 1, rd);
    wb(1, OFS_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq", 1, irq);
    wb(1, OFS_STAT, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq clear", 0, irq);
    wb(1, OFS_STRB, 32'h1);
    $display("irq test done");
  endtask : t_irq
  task t_tare;
    meas(X50, ALL, 18'h0, CPM);
    contact_input <= 1;
    repeat (3) @(posedge clock);
    contact_input <= 0;
    wb(0, OFS_STAT, 0);
    chk("tare flag", 4, rd & 4);
    wb(0, OFS_TARE, 0);
    chk("tare", 32'h0008_0000, rd);
    meas(X50, ALL, {16'h1000, 2'b10}, CPM);
    wb(1, OFS_TARE, 0);
    $display("tare test done");
  endtask : t_tare
  // ==========
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    t_reset();
    t_codes();
    t_ovr();
    t_hold();
    t_irq();
    t_tare();
    end_of_test();
  end
endmodule : sdpo_parallel_out_tb
